// ### hdl/gdmac_channel.sv
// general-purpose dma channel: register slave, dual-address engine
`timescale 1ns/1ps
`default_nettype none
module gdmac_channel (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // avalon-mm register slave
  input wire logic [2:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // internal module bus master
  output logic [31:0] M_ADDR,
  output logic [3:0] M_SPACE,
  output logic [2:0] M_SIZE,
  output logic M_READ,
  output logic M_WRITE,
  output logic [31:0] M_WDATA,
  input wire logic [31:0] M_RDATA,
  input wire logic M_ACK,
  input wire logic M_ERR,
  // peripheral pins
  input wire logic PERIPH_REQUEST_PIN,
  input wire logic TRANSFER_END_PIN_I,
  output logic TRANSFER_END_PIN_O,
  output logic TRANSFER_END_PIN_OE,
  input wire logic BREAKPOINT,
  // descriptor controller side
  input wire logic DESC_INT,
  input wire logic DESC_LAST,
  input wire logic DESC_NONE,
  output logic BUF_END,
  // masked event request
  output logic IRQ
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = n[8*i +: 8];
      end
    end
    return m;
  endfunction

  // operand bytes limited by port size, address alignment and bytes left
  function automatic logic [2:0] chunk(input logic [1:0] sz, input logic [1:0] a,
                                       input logic [32:0] left);
    logic [2:0] c;
    c = (sz == gdmac_pkg::SZ_LONG) ? 3'h4 : (sz == gdmac_pkg::SZ_WORD) ? 3'h2 : 3'h1;
    if (a[0]) begin
      c = 3'h1;
    end else if (a[1] && c == 3'h4) begin
      c = 3'h2;
    end
    if (left < {30'h0, c}) begin
      c = left[2:0];
    end
    return c;
  endfunction

  function automatic logic [31:0] lanes(input logic [2:0] n);
    return (n == 3'h1) ? 32'h0000_00ff : (n == 3'h2) ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [15:0] mode_r;
  logic [31:0] src_r, dst_r, cnt_r;
  logic [7:0] codes_r, ev_r, evmask_r;
  logic resp_r, stop_req_r, buf_wait_r, edge_pend_r, req_prev_r;
  logic [31:0] rdata_r;
  logic [55:0] hold_r;
  logic [2:0] held_r;
  logic [9:0] win_r, busy_r;
  gdmac_pkg::gdmac_state_type st_r;
  logic [31:0] m_addr_r, m_wdata_r;
  logic [3:0] m_space_r;
  logic [2:0] m_size_r;
  logic m_rd_r, m_wr_r, end_oe_r, buf_end_r, irq_r;

  // ****************************************
  // register slave decode
  // ****************************************
  logic acc, wr_en;
  logic [31:0] wmerge_mode;
  logic [7:0] ev_clr;
  assign acc = AVS_READ | AVS_WRITE;
  // one wait cycle on every access; write lands at the released edge
  assign AVS_WAITREQUEST = acc & ~resp_r;
  assign wr_en = AVS_WRITE & resp_r;
  assign wmerge_mode = merge({16'h0, mode_r}, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign ev_clr = (wr_en && AVS_ADDRESS == gdmac_pkg::REG_EVENTS && AVS_BYTEENABLE[0]) ?
                  AVS_WRITEDATA[7:0] : 8'h00;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      resp_r <= 1'b0;
    end else begin
      resp_r <= acc & ~resp_r;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rdata_r <= 32'h0000_0000;
    end else if (AVS_READ && !resp_r) begin
      case (AVS_ADDRESS)
        gdmac_pkg::REG_MODE: rdata_r <= {16'h0, mode_r};
        gdmac_pkg::REG_SRC: rdata_r <= src_r;
        gdmac_pkg::REG_DST: rdata_r <= dst_r;
        gdmac_pkg::REG_CODES: rdata_r <= {24'h0, codes_r};
        gdmac_pkg::REG_COUNT: rdata_r <= cnt_r;
        gdmac_pkg::REG_EVENTS: rdata_r <= {24'h0, ev_r};
        gdmac_pkg::REG_EVMASK: rdata_r <= {24'h0, evmask_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign AVS_READDATA = rdata_r;

  // ****************************************
  // engine decisions
  // ****************************************
  logic rst_now, run, risc, idle, op_busy, go, req_ok, can_wr;
  logic rd_done, rd_err, wr_done, wr_err, last_wr, ext_end, nodesc, stop_now, end_now;
  logic [1:0] request_source_select;
  logic [9:0] bw_lim;
  logic [32:0] total, rd_left;
  logic [2:0] wchunk, rchunk;
  logic [31:0] cnt_after;
  logic [7:0] ev_set;
  assign rst_now = mode_r[gdmac_pkg::M_RST];
  assign run = mode_r[gdmac_pkg::M_RUN];
  assign risc = mode_r[gdmac_pkg::M_RISC];
  assign request_source_select = mode_r[gdmac_pkg::M_REQ +: 2];
  assign idle = (st_r == gdmac_pkg::ST_IDLE);
  // an operand is finished only when the packing buffer is empty again
  assign op_busy = !idle || held_r != 3'h0;
  // RL14 zero means four gigabytes
  assign total = {cnt_r == 32'h0, cnt_r};
  assign rd_left = total - {30'h0, held_r};
  // RL1 destination width decode
  assign wchunk = chunk(mode_r[gdmac_pkg::M_DSZ +: 2], dst_r[1:0], total);
  assign rchunk = chunk(mode_r[gdmac_pkg::M_SSZ +: 2], src_r[1:0], rd_left);
  assign can_wr = held_r != 3'h0 && held_r >= wchunk;

  always_comb begin
    case (mode_r[gdmac_pkg::M_BW +: 2])
      2'h0: bw_lim = gdmac_pkg::BW_75;
      2'h1: bw_lim = gdmac_pkg::BW_50;
      2'h2: bw_lim = gdmac_pkg::BW_25;
      default: bw_lim = gdmac_pkg::BW_12;
    endcase
  end

  // RL23 request source decode
  always_comb begin
    case (request_source_select)
      // RL3 cap only for limited rate
      gdmac_pkg::REQ_LIMITED: req_ok = busy_r < bw_lim;
      gdmac_pkg::REQ_MAX: req_ok = 1'b1;
      gdmac_pkg::REQ_LEVEL: req_ok = PERIPH_REQUEST_PIN;
      default: req_ok = edge_pend_r;
    endcase
  end

  // RL5 nothing issues without run
  // a pending stop still lets the open operand drain, else run would read one forever
  assign go = run && (!stop_req_r || held_r != 3'h0) && !buf_wait_r && req_ok && !rst_now
              && idle;
  assign rd_done = st_r == gdmac_pkg::ST_READ && M_ACK && !M_ERR;
  assign rd_err = st_r == gdmac_pkg::ST_READ && M_ACK && M_ERR;
  assign wr_done = st_r == gdmac_pkg::ST_WRITE && M_ACK && !M_ERR;
  assign wr_err = st_r == gdmac_pkg::ST_WRITE && M_ACK && M_ERR;
  assign cnt_after = cnt_r - {29'h0, m_size_r};
  assign last_wr = wr_done && cnt_after == 32'h0;
  // peripheral end input counts only when we are not driving it
  assign ext_end = !idle && M_ACK && !M_ERR && !end_oe_r && !TRANSFER_END_PIN_I;
  assign nodesc = risc && run && DESC_NONE;
  // RL6 pause only between operands
  assign stop_now = stop_req_r && !op_busy;
  assign end_now = rd_err || wr_err || ext_end || nodesc || (last_wr && (!risc || DESC_LAST));

  // RL25 event bit placement
  always_comb begin
    ev_set = 8'h00;
    // RL20 clean completion only
    ev_set[gdmac_pkg::EV_DONE] = (last_wr && (!risc || DESC_LAST)) || ext_end;
    // RL19 error source by cycle type
    ev_set[gdmac_pkg::EV_WERR] = wr_err;
    ev_set[gdmac_pkg::EV_RERR] = rd_err;
    // RL18 descriptors exhausted
    ev_set[gdmac_pkg::EV_NODESC] = nodesc;
    // RL17 breakpoint mid transfer
    ev_set[gdmac_pkg::EV_BRK] = BREAKPOINT && !idle;
    // RL16 auxiliary done on interrupting buffer
    ev_set[gdmac_pkg::EV_AUX] = last_wr && risc && !DESC_LAST && DESC_INT;
  end

  // ****************************************
  // software registers
  // ****************************************
  // RL4 soft reset clears mode and itself
  always_ff @(posedge CORE_CLK) begin
    if (RESET || rst_now) begin
      mode_r <= gdmac_pkg::MODE_RST_VAL;
    end else begin
      if (wr_en && AVS_ADDRESS == gdmac_pkg::REG_MODE) begin
        mode_r[15:1] <= wmerge_mode[15:1];
        // RL8 run reads one while an operand is open
        mode_r[gdmac_pkg::M_RUN] <= wmerge_mode[gdmac_pkg::M_RUN] | (run & op_busy);
      end
      // RL7 self clear on completion
      if (stop_now || end_now) begin
        mode_r[gdmac_pkg::M_RUN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET || rst_now) begin
      stop_req_r <= 1'b0;
    end else if (wr_en && AVS_ADDRESS == gdmac_pkg::REG_MODE) begin
      stop_req_r <= !wmerge_mode[gdmac_pkg::M_RUN] && run && op_busy;
    end else if (stop_now || end_now) begin
      stop_req_r <= 1'b0;
    end
  end

  // RL11 space code register
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      codes_r <= gdmac_pkg::CODES_RST_VAL;
    end else if (wr_en && AVS_ADDRESS == gdmac_pkg::REG_CODES && AVS_BYTEENABLE[0]) begin
      codes_r <= AVS_WRITEDATA[7:0];
    end
  end

  // RL21 mask register, cleared at reset
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      evmask_r <= gdmac_pkg::EV_RST_VAL;
    end else if (wr_en && AVS_ADDRESS == gdmac_pkg::REG_EVMASK && AVS_BYTEENABLE[0]) begin
      evmask_r <= AVS_WRITEDATA[7:0] & gdmac_pkg::EV_USED;
    end
  end

  // RL15 sticky events, set beats clear
  always_ff @(posedge CORE_CLK) begin
    if (RESET || rst_now) begin
      ev_r <= gdmac_pkg::EV_RST_VAL;
    end else begin
      ev_r <= ((ev_r & ~ev_clr) | ev_set) & gdmac_pkg::EV_USED;
    end
  end

  // RL21 masked events request service
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(ev_r & evmask_r);
    end
  end
  assign IRQ = irq_r;

  // RL9 source pointer, unsigned wrap
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      src_r <= 32'h0000_0000;
    end else if (wr_en && AVS_ADDRESS == gdmac_pkg::REG_SRC) begin
      src_r <= merge(src_r, AVS_WRITEDATA, AVS_BYTEENABLE);
    end else if (rd_done && mode_r[gdmac_pkg::M_SINC]) begin
      src_r <= src_r + {29'h0, m_size_r};
    end
  end

  // RL10 destination pointer, unsigned wrap
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      dst_r <= 32'h0000_0000;
    end else if (wr_en && AVS_ADDRESS == gdmac_pkg::REG_DST) begin
      dst_r <= merge(dst_r, AVS_WRITEDATA, AVS_BYTEENABLE);
    end else if (wr_done && mode_r[gdmac_pkg::M_DINC]) begin
      dst_r <= dst_r + {29'h0, m_size_r};
    end
  end

  // RL13 count down per byte written
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      cnt_r <= 32'h0000_0000;
    end else if (wr_en && AVS_ADDRESS == gdmac_pkg::REG_COUNT) begin
      cnt_r <= merge(cnt_r, AVS_WRITEDATA, AVS_BYTEENABLE);
    end else if (wr_done) begin
      cnt_r <= cnt_after;
    end
  end

  // a finished non-last buffer waits for the counter to be reloaded
  always_ff @(posedge CORE_CLK) begin
    if (RESET || rst_now) begin
      buf_wait_r <= 1'b0;
      buf_end_r <= 1'b0;
    end else begin
      buf_end_r <= last_wr && risc && !DESC_LAST;
      if (wr_en && AVS_ADDRESS == gdmac_pkg::REG_COUNT) begin
        buf_wait_r <= 1'b0;
      end else if (last_wr && risc && !DESC_LAST) begin
        buf_wait_r <= 1'b1;
      end
    end
  end
  assign BUF_END = buf_end_r;

  // ****************************************
  // request pacing
  // ****************************************
  // RL5 edges caught only while running
  always_ff @(posedge CORE_CLK) begin
    if (RESET || rst_now) begin
      req_prev_r <= 1'b0;
      edge_pend_r <= 1'b0;
    end else begin
      req_prev_r <= PERIPH_REQUEST_PIN;
      if (run && PERIPH_REQUEST_PIN && !req_prev_r) begin
        edge_pend_r <= 1'b1;
      end else if (wr_done || !run) begin
        edge_pend_r <= 1'b0;
      end
    end
  end

  // RL2 busy cycles per 1024-cycle window
  always_ff @(posedge CORE_CLK) begin
    if (RESET || rst_now || !run) begin
      win_r <= 10'h000;
      busy_r <= 10'h000;
    end else begin
      win_r <= win_r + 10'h001;
      if (win_r == 10'h3ff) begin
        busy_r <= 10'h000;
      end else if (!idle) begin
        busy_r <= busy_r + 10'h001;
      end
    end
  end

  // ****************************************
  // bus cycles and packing
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (RESET || rst_now) begin
      st_r <= gdmac_pkg::ST_IDLE;
      m_rd_r <= 1'b0;
      m_wr_r <= 1'b0;
      m_addr_r <= 32'h0000_0000;
      m_space_r <= 4'h0;
      m_size_r <= 3'h0;
      m_wdata_r <= 32'h0000_0000;
      end_oe_r <= 1'b0;
    end else begin
      case (st_r)
        gdmac_pkg::ST_IDLE: begin
          if (go && can_wr) begin
            st_r <= gdmac_pkg::ST_WRITE;
            m_wr_r <= 1'b1;
            m_addr_r <= dst_r;
            m_space_r <= codes_r[7:4];
            m_size_r <= wchunk;
            m_wdata_r <= hold_r[31:0] & lanes(wchunk);
            // RL24 drive end pin on final write
            end_oe_r <= total == {30'h0, wchunk};
          end else if (go && rd_left != 33'h0) begin
            st_r <= gdmac_pkg::ST_READ;
            m_rd_r <= 1'b1;
            m_addr_r <= src_r;
            m_space_r <= codes_r[3:0];
            m_size_r <= rchunk;
          end
        end
        gdmac_pkg::ST_READ, gdmac_pkg::ST_WRITE: begin
          // RL4 end the cycle when acknowledged
          if (M_ACK) begin
            st_r <= gdmac_pkg::ST_IDLE;
            m_rd_r <= 1'b0;
            m_wr_r <= 1'b0;
            end_oe_r <= 1'b0;
          end
        end
        default: st_r <= gdmac_pkg::ST_IDLE;
      endcase
    end
  end

  // RL22 pack on reads, unpack on writes
  always_ff @(posedge CORE_CLK) begin
    if (RESET || rst_now) begin
      hold_r <= 56'h0;
      held_r <= 3'h0;
    end else if (rd_done) begin
      hold_r <= hold_r | ({24'h0, M_RDATA & lanes(m_size_r)} << {held_r, 3'b000});
      held_r <= held_r + m_size_r;
    end else if (wr_done) begin
      hold_r <= hold_r >> {m_size_r, 3'b000};
      held_r <= held_r - m_size_r;
    end else if (end_now) begin
      hold_r <= 56'h0;
      held_r <= 3'h0;
    end
  end

  assign M_READ = m_rd_r;
  assign M_WRITE = m_wr_r;
  assign M_ADDR = m_addr_r;
  assign M_SPACE = m_space_r;
  assign M_SIZE = m_size_r;
  assign M_WDATA = m_wdata_r;
  assign TRANSFER_END_PIN_O = 1'b0;
  assign TRANSFER_END_PIN_OE = end_oe_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  a_soft_reset: assert property (rst_now |=> mode_r == 16'h0 && ev_r == 8'h0 && idle) // RL4
    else $error("soft reset did not clear channel");
  a_run_gate: assert property (idle && !run |=> idle) // RL5
    else $error("cycle issued while stopped");
  a_run_held: assert property (wr_en && AVS_ADDRESS == gdmac_pkg::REG_MODE && run
                               && op_busy && !end_now |=> run) // RL8
    else $error("run dropped mid operand");
  a_auto_stop: assert property (last_wr && !risc |=> !run && ev_r[gdmac_pkg::EV_DONE]) // RL7
    else $error("completion did not stop channel");
  a_src_step: assert property (rd_done && mode_r[gdmac_pkg::M_SINC]
      && !(wr_en && AVS_ADDRESS == gdmac_pkg::REG_SRC)
      |=> src_r == $past(src_r) + {29'h0, $past(m_size_r)}) // RL9
    else $error("source pointer step wrong");
  a_cnt_step: assert property (wr_done && !(wr_en && AVS_ADDRESS == gdmac_pkg::REG_COUNT)
      |=> cnt_r == $past(cnt_after)) // RL13
    else $error("byte counter step wrong");
  a_read_space: assert property ($rose(M_READ) |-> M_SPACE == $past(codes_r[3:0])) // RL11
    else $error("read space code wrong");
  a_byte_dest: assert property ($rose(M_WRITE) && mode_r[gdmac_pkg::M_DSZ +: 2]
      == gdmac_pkg::SZ_BYTE |-> M_SIZE == 3'h1) // RL1
    else $error("byte destination not byte wide");
  a_bw_cap: assert property ($rose(M_READ | M_WRITE) && request_source_select == gdmac_pkg::REQ_LIMITED
      |-> $past(busy_r) < $past(bw_lim)) // RL2
    else $error("bandwidth cap exceeded");
  a_read_error: assert property (rd_err |=> ev_r[gdmac_pkg::EV_RERR] && !run
      && !$rose(ev_r[gdmac_pkg::EV_DONE])) // RL19
    else $error("read error not flagged");
  a_irq_mask: assert property (##1 (ev_r & evmask_r) == 8'h0 |=> !IRQ) // RL21
    else $error("masked event raised request");

  c_done: cover property ($rose(ev_r[gdmac_pkg::EV_DONE]));
  c_pause: cover property (stop_now);
  c_pack: cover property (wr_done && held_r > m_size_r);
  c_error: cover property (rd_err || wr_err);
endmodule
`default_nettype wire

// ### hdl/gdmac_pkg.sv
// constants and types for one general-purpose dma channel
// How it works
// RL1 - destination size code picks write width
// RL2 - burst field caps bus share per window
// RL3 - cap applies only in limited-rate mode
// RL4 - reset bit aborts, clears status and mode
// RL5 - run bit starts; requests ignored without it
// RL6 - clearing run pauses; setting again resumes
// RL7 - run bit self-clears on completion
// RL8 - run reads one until operand ends
// RL9 - source pointer drives reads, steps, wraps
// RL10 - destination pointer drives writes, steps, wraps
// RL11 - space codes: write high nibble, read low
// RL12 - software avoids code 0x77
// RL13 - counter drops per moved byte; zero ends
// RL14 - counter zero means four gigabytes
// RL15 - events sticky, write one clears
// RL16 - descriptor with interrupt sets auxiliary done
// RL17 - breakpoint during transfer sets flag
// RL18 - no valid descriptors sets flag
// RL19 - bus errors set read/write error, stop
// RL20 - normal done only on clean end
// RL21 - mask gates events onto interrupt
// RL22 - hidden buffer packs and unpacks operands
// RL23 - request source decode, four modes
// RL24 - end pin driven on final transfer
// RL25 - event bits five down to zero
package gdmac_pkg;
  // register word indexes on the slave port
  localparam logic [2:0] REG_MODE = 3'h0;
  localparam logic [2:0] REG_SRC = 3'h1;
  localparam logic [2:0] REG_DST = 3'h2;
  localparam logic [2:0] REG_CODES = 3'h3;
  localparam logic [2:0] REG_COUNT = 3'h4;
  localparam logic [2:0] REG_EVENTS = 3'h5;
  localparam logic [2:0] REG_EVMASK = 3'h6;
  // channel_mode field positions
  localparam int M_RUN = 0;
  localparam int M_RST = 1;
  localparam int M_BW = 2;
  localparam int M_DSZ = 4;
  localparam int M_SSZ = 6;
  localparam int M_DINC = 8;
  localparam int M_SINC = 9;
  localparam int M_REQ = 10;
  localparam int M_RISC = 12;
  // channel_events bit positions
  localparam int EV_DONE = 0;
  localparam int EV_WERR = 1;
  localparam int EV_RERR = 2;
  localparam int EV_NODESC = 3;
  localparam int EV_BRK = 4;
  localparam int EV_AUX = 5;
  localparam logic [7:0] EV_USED = 8'h3f;
  // reset values
  localparam logic [15:0] MODE_RST_VAL = 16'h0000;
  localparam logic [7:0] CODES_RST_VAL = 8'h00;
  localparam logic [7:0] EV_RST_VAL = 8'h00;
  // operand size and request source codes
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] REQ_LIMITED = 2'h0;
  localparam logic [1:0] REQ_MAX = 2'h1;
  localparam logic [1:0] REQ_LEVEL = 2'h2;
  localparam logic [1:0] REQ_EDGE = 2'h3;
  // bandwidth window of 1024 cycles and busy-cycle caps
  localparam int WIN_BITS = 10;
  localparam logic [9:0] BW_75 = 10'h300;
  localparam logic [9:0] BW_50 = 10'h200;
  localparam logic [9:0] BW_25 = 10'h100;
  localparam logic [9:0] BW_12 = 10'h080;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READ = 2'h1,
    ST_WRITE = 2'h3
  } gdmac_state_type;
endpackage

// ### testbench/gdmac_mem_model.sv
// memory model answering the channel on the internal module bus
`timescale 1ns/1ps
`default_nettype none
module gdmac_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus from the channel
  input wire logic m_read,
  input wire logic m_write,
  input wire logic [31:0] m_addr,
  input wire logic [3:0] m_space,
  input wire logic [2:0] m_size,
  input wire logic [31:0] m_wdata,
  output logic [31:0] m_rdata,
  output logic m_ack,
  output logic m_err,
  // test controls and capture
  input wire logic [3:0] delay,
  input wire logic err_rd,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [2:0] wr_size,
  output logic [3:0] wr_space,
  output logic [3:0] rd_space
);
  logic [3:0] cnt_r;
  logic [7:0] a;
  assign a = m_addr[7:0];
  always_ff @(posedge clk) begin
    m_ack <= 1'b0;
    m_err <= 1'b0;
    // data is only valid with ack, so it keeps changing to expose late sampling
    m_rdata <= ~m_rdata;
    if (rst) begin
      cnt_r <= 4'h0;
      m_rdata <= 32'h0;
    end else if ((m_read || m_write) && !m_ack) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r >= delay) begin
        cnt_r <= 4'h0;
        m_ack <= 1'b1;
        m_err <= m_read && err_rd;
        if (m_read) begin
          m_rdata <= {a + 8'h3, a + 8'h2, a + 8'h1, a};
          rd_space <= m_space;
        end else begin
          wr_addr <= m_addr;
          wr_data <= m_wdata;
          wr_size <= m_size;
          wr_space <= m_space;
        end
      end
    end else begin
      cnt_r <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb_general_dma_channel_control.sv
// self-checking testbench for the general dma channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin \
  $display("[FAIL] %s expected %h seen %h", nm, e, a); err_count++; end end
module tb_general_dma_channel_control;
  logic clk, rst, rd, wr, preq, brk, endi, dint, dlast, dnone, erd, oe_seen, rd_seen;
  logic [2:0] addr, msize, wsize;
  logic [3:0] be, dly, mspace, wspace, rspace;
  logic [31:0] wdat, rdata, rv, maddr, mwdata, mrdata, waddr, wdata;
  logic wreq, mread, mwrite, mack, merr, endo, oe, bufend, irq;
  int err_count, comparisons;
  // ****
  // design and memory
  // ****
  gdmac_channel DUT (.CORE_CLK(clk), .RESET(rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .M_ADDR(maddr), .M_SPACE(mspace), .M_SIZE(msize),
    .M_READ(mread), .M_WRITE(mwrite), .M_WDATA(mwdata), .M_RDATA(mrdata), .M_ACK(mack),
    .M_ERR(merr), .PERIPH_REQUEST_PIN(preq), .TRANSFER_END_PIN_I(endi),
    .TRANSFER_END_PIN_O(endo), .TRANSFER_END_PIN_OE(oe), .BREAKPOINT(brk),
    .DESC_INT(dint), .DESC_LAST(dlast), .DESC_NONE(dnone), .BUF_END(bufend), .IRQ(irq));
  gdmac_mem_model mem (.clk(clk), .rst(rst), .m_read(mread), .m_write(mwrite),
    .m_addr(maddr), .m_space(mspace), .m_size(msize), .m_wdata(mwdata), .m_rdata(mrdata),
    .m_ack(mack), .m_err(merr), .delay(dly), .err_rd(erd), .wr_addr(waddr),
    .wr_data(wdata), .wr_size(wsize), .wr_space(wspace), .rd_space(rspace));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) begin
    if (mwrite && oe) oe_seen = 1'b1;
    if (mread) rd_seen = 1'b1;
  end
  // ****
  // tasks
  // ****
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdat <= d;
    // waitrequest and read data are taken at the rising edge that ends the wait
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) err_count++;
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wait_idle();
    repeat (100) begin
      bus(1'b0, gdmac_pkg::REG_MODE, 32'h0);
      if (rv[0] === 1'b0) break;
    end
  endtask
  task automatic setup(input logic [31:0] s, input logic [31:0] d, input logic [31:0] n);
    bus(1'b1, gdmac_pkg::REG_SRC, s);
    bus(1'b1, gdmac_pkg::REG_DST, d);
    bus(1'b1, gdmac_pkg::REG_COUNT, n);
  endtask
  task automatic t_reset();
    bus(1'b0, gdmac_pkg::REG_MODE, 32'h0);
    `CHK("mode", 16'h0, rv[15:0])
    bus(1'b0, gdmac_pkg::REG_CODES, 32'h0);
    `CHK("codes", 8'h00, rv[7:0])
    bus(1'b0, gdmac_pkg::REG_EVENTS, 32'h0);
    `CHK("events", 8'h00, rv[7:0])
    bus(1'b0, gdmac_pkg::REG_EVMASK, 32'h0);
    `CHK("mask", 8'h00, rv[7:0])
    bus(1'b0, 3'h7, 32'h0);
    `CHK("unmapped", 32'h0, rv)
    $display("test reset done");
  endtask
  task automatic t_pack();
    dly <= 4'h2;
    setup(32'h100, 32'h200, 32'h2);
    // dma space code pattern with bit 7 and bit 3 set
    bus(1'b1, gdmac_pkg::REG_CODES, 32'h9a);
    bus(1'b1, gdmac_pkg::REG_EVMASK, 32'h01);
    oe_seen = 1'b0;
    bus(1'b1, gdmac_pkg::REG_MODE, 32'h761);
    brk <= 1'b1;
    wait_idle();
    brk <= 1'b0;
    `CHK("run", 1'b0, rv[0])
    `CHK("wdata", 32'h0100, wdata)
    `CHK("wsize", 3'h2, wsize)
    `CHK("waddr", 32'h200, waddr)
    `CHK("wspace", 4'h9, wspace)
    `CHK("rspace", 4'ha, rspace)
    `CHK("end pin", 1'b1, oe_seen)
    bus(1'b0, gdmac_pkg::REG_SRC, 32'h0);
    `CHK("src", 32'h102, rv)
    bus(1'b0, gdmac_pkg::REG_COUNT, 32'h0);
    `CHK("count", 32'h0, rv)
    bus(1'b1, gdmac_pkg::REG_EVENTS, 32'h0);
    bus(1'b0, gdmac_pkg::REG_EVENTS, 32'h0);
    `CHK("events", 8'h11, rv[7:0])
    `CHK("irq", 1'b1, irq)
    bus(1'b1, gdmac_pkg::REG_EVENTS, 32'h11);
    bus(1'b0, gdmac_pkg::REG_EVENTS, 32'h0);
    `CHK("cleared", 8'h00, rv[7:0])
    `CHK("irq off", 1'b0, irq)
    $display("test pack done");
  endtask
  task automatic t_err();
    dly <= 4'h0;
    erd <= 1'b1;
    oe_seen = 1'b0;
    setup(32'h300, 32'h400, 32'h4);
    // limited-rate request source, well under its cap
    bus(1'b1, gdmac_pkg::REG_MODE, 32'h301);
    wait_idle();
    erd <= 1'b0;
    bus(1'b0, gdmac_pkg::REG_EVENTS, 32'h0);
    `CHK("events", 8'h04, rv[7:0])
    `CHK("no write", 1'b0, oe_seen)
    $display("test error done");
  endtask
  task automatic t_soft();
    dly <= 4'hf;
    rd_seen = 1'b0;
    setup(32'h300, 32'h400, 32'h4);
    bus(1'b1, gdmac_pkg::REG_MODE, 32'h701);
    // first read strobe rises one cycle after run lands
    repeat (2) @(posedge clk);
    `CHK("started", 1'b1, rd_seen)
    bus(1'b1, gdmac_pkg::REG_MODE, 32'h2);
    bus(1'b0, gdmac_pkg::REG_MODE, 32'h0);
    `CHK("mode", 16'h0, rv[15:0])
    `CHK("bus off", 1'b0, mread)
    bus(1'b0, gdmac_pkg::REG_EVENTS, 32'h0);
    `CHK("events", 8'h00, rv[7:0])
    $display("test soft reset done");
  endtask
  task automatic t_ext();
    dly <= 4'h1;
    setup(32'h500, 32'h600, 32'h1);
    bus(1'b1, gdmac_pkg::REG_MODE, 32'h850);
    preq <= 1'b1;
    rd_seen = 1'b0;
    repeat (20) @(posedge clk);
    `CHK("ignored", 1'b0, rd_seen)
    bus(1'b1, gdmac_pkg::REG_MODE, 32'h851);
    wait_idle();
    `CHK("waddr", 32'h600, waddr)
    bus(1'b0, gdmac_pkg::REG_EVENTS, 32'h0);
    `CHK("done", 8'h01, rv[7:0])
    bus(1'b1, gdmac_pkg::REG_EVENTS, 32'h1);
    bus(1'b1, gdmac_pkg::REG_COUNT, 32'h1);
    rd_seen = 1'b0;
    bus(1'b1, gdmac_pkg::REG_MODE, 32'hc51);
    repeat (20) @(posedge clk);
    // a request held high is no edge
    `CHK("no edge", 1'b0, rd_seen)
    preq <= 1'b0;
    @(posedge clk);
    preq <= 1'b1;
    wait_idle();
    preq <= 1'b0;
    `CHK("edge run", 1'b1, rd_seen)
    $display("test external done");
  endtask
  task automatic t_risc();
    int n;
    n = 0;
    dint <= 1'b1;
    bus(1'b1, gdmac_pkg::REG_EVENTS, 32'hff);
    setup(32'h700, 32'h800, 32'h1);
    bus(1'b1, gdmac_pkg::REG_MODE, 32'h1451);
    while (bufend !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    `CHK("buffer end", 1'b1, bufend)
    dnone <= 1'b1;
    wait_idle();
    dnone <= 1'b0;
    dint <= 1'b0;
    bus(1'b0, gdmac_pkg::REG_EVENTS, 32'h0);
    `CHK("events", 8'h28, rv[7:0])
    `CHK("end drive", 1'b0, endo)
    $display("test descriptor done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    err_count = 0;
    comparisons = 0;
    {rd, wr, preq, brk, dint, dlast, dnone, erd} = 8'h0;
    {addr, wdat, dly} = 39'h0;
    endi = 1'b1;
    be = 4'hf;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pack();
    t_err();
    t_soft();
    t_ext();
    t_risc();
    complete_run();
  end
  initial begin
    #800000;
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
